// *** core/arrs_core.sv ***
// reclose record counters, history, input display and signal routing
`timescale 1ns/100ps
`default_nettype none
module arrs_core (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             resetn,
	// wishbone slave
	input  wire logic [7:0]       wb_adr_i,
	input  wire logic [31:0]      wb_dat_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic             wb_we_i,
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	output logic      [31:0]      wb_dat_o,
	output logic                  wb_ack_o,
	// external control inputs
	input  wire logic             reclose_start_a,
	input  wire logic             reclose_start_b,
	input  wire logic             reclose_start_c,
	input  wire logic             reclose_inhibit_input,
	input  wire logic             reclose_control_input,
	input  wire logic             blocking_input,
	input  wire logic             remote_reset_input,
	input  wire logic             breaker_pos_input,
	// sequencer events and module signals
	input  wire arrs_pkg::arrs_evt_t evt,
	input  wire logic [10:0]      module_signals,
	// routed control functions
	output logic                  reclose_start_d,
	output logic                  start_c_routed,
	output logic                  synchrocheck_ok,
	output logic                  breaker_close_inhibit,
	output logic                  indicator_reset,
	output logic                  record_reset,
	// output relays
	output logic      [3:0]       signalling_outputs,
	output logic      [2:0]       trip_outputs,
	// record display
	output logic      [3:0]       disp_code,
	output logic      [11:0]      disp_value
);
	// ------------------------------------------------
	// state
	// ------------------------------------------------
	logic [9:0]  tot_r [arrs_pkg::NCNT];
	logic [7:0]  sub_r [arrs_pkg::NCNT][arrs_pkg::NSRC];
	logic [4:0]  hist_r [arrs_pkg::NSLOT+1];
	logic [7:0]  sgb_r [arrs_pkg::NSGB];
	logic [6:0]  sgr_r [arrs_pkg::NSGR];
	logic [3:0]  dsel_r;
	logic        ack_r;
	logic [31:0] dat_r;
	logic [31:0] rd_nxt;
	// checks below all run on the core clock
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	// ------------------------------------------------
	// bus decode
	// ------------------------------------------------
	wire logic [5:0] idx   = wb_adr_i[7:2];
	wire logic       req   = wb_cyc_i && wb_stb_i && !ack_r;
	wire logic       wr_b0 = req && wb_we_i && wb_sel_i[0];
	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;

	// ------------------------------------------------
	// input state display
	// ------------------------------------------------
	// right digit weights inhibit, control, blocking
	wire logic [3:0] dig_rt = {1'b0, blocking_input,
		reclose_control_input, reclose_inhibit_input};
	// energized position input means breaker open
	wire logic [3:0] dig_m = {3'h0, !breaker_pos_input};
	wire logic [3:0] dig_l = {1'b0, reclose_start_c,
		reclose_start_b, reclose_start_a};
	wire logic [11:0] disp_word = {dig_l, dig_m, dig_rt};

	// ------------------------------------------------
	// control signal routing
	// ------------------------------------------------
	// group order: control, blocking, remote reset
	wire logic [2:0] ctl = {remote_reset_input, blocking_input,
		reclose_control_input};
	logic [4:0] fn_hit;
	always_comb begin
		fn_hit = 5'h0;
		// switches 1 to 5 reach functions here; switch 6 of the blocking group links start c below
		for (int g = 0; g < arrs_pkg::NSGB; g++) begin
			fn_hit = fn_hit | ({5{ctl[g]}} & sgb_r[g][4:0]);
		end
	end
	wire logic link_c = blocking_input
		&& sgb_r[arrs_pkg::GRP_BLK][arrs_pkg::SW_LINKC];
	wire logic rec_clr = fn_hit[arrs_pkg::SW_RECRST];

	// ------------------------------------------------
	// output relay routing
	// ------------------------------------------------
	logic [6:0] out_nxt;
	always_comb begin
		out_nxt = 7'h0;
		for (int g = 0; g < arrs_pkg::NSGR; g++) begin
			out_nxt = out_nxt | ({7{module_signals[g]}} & sgr_r[g]);
		end
	end

	// routed outputs registered
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			reclose_start_d       <= 1'b0;
			start_c_routed        <= 1'b0;
			synchrocheck_ok       <= 1'b0;
			breaker_close_inhibit <= 1'b0;
			indicator_reset       <= 1'b0;
			record_reset          <= 1'b0;
			signalling_outputs    <= 4'h0;
			trip_outputs          <= 3'h0;
		end else begin
			reclose_start_d       <= fn_hit[arrs_pkg::SW_STARTD];
			start_c_routed        <= reclose_start_c || link_c;
			synchrocheck_ok       <= fn_hit[arrs_pkg::SW_SYNC];
			breaker_close_inhibit <= fn_hit[arrs_pkg::SW_BREAKER_CLOSE_INHIBIT];
			indicator_reset       <= fn_hit[arrs_pkg::SW_INDRST]
				|| rec_clr;
			record_reset          <= rec_clr;
			signalling_outputs    <= out_nxt[3:0];
			trip_outputs          <= out_nxt[6:4];
		end
	end

	// routed outputs follow their switches
	start_d_route_a: assert property (
		reclose_control_input && sgb_r[0][0] |=> reclose_start_d)
		else $error("start d not routed");
	sync_route_a: assert property (
		blocking_input && sgb_r[1][1] |=> synchrocheck_ok)
		else $error("synchrocheck not routed");
	rec_reset_route_a: assert property (
		remote_reset_input && sgb_r[2][4] |=> record_reset && indicator_reset)
		else $error("record reset not routed");
	spare_switch_a: assert property (
		sgb_r[0][4:0] == 5'h0 && sgb_r[1][4:0] == 5'h0 && sgb_r[2][4:0] == 5'h0
		|=> !reclose_start_d && !synchrocheck_ok && !breaker_close_inhibit && !record_reset)
		else $error("unused switch drove a function");
	start_c_pass_a: assert property (
		reclose_start_c |=> start_c_routed)
		else $error("start c not passed through");
	relay_idle_a: assert property (
		module_signals == 11'h000 |=> signalling_outputs == 4'h0 && trip_outputs == 3'h0)
		else $error("relay active with no signal");

	// ------------------------------------------------
	// shot and alarm counters
	// ------------------------------------------------
	// counter 0..4 are shots 1..5, counter 5 is alarms
	logic [arrs_pkg::NCNT-1:0] cnt_inc;
	always_comb begin
		for (int i = 0; i < arrs_pkg::NCNT - 1; i++) begin
			cnt_inc[i] = evt.shot_done
				&& (evt.shot_num == 3'(i + 1));
		end
		cnt_inc[arrs_pkg::NCNT-1] = evt.alarm;
	end

	for (genvar i = 0; i < arrs_pkg::NCNT; i++) begin : g_cnt
		// total, stops at its maximum
		always_ff @(posedge core_clk) begin
			if (!resetn || rec_clr) begin
				tot_r[i] <= 10'h0;
			end else if (cnt_inc[i] && tot_r[i] != arrs_pkg::TOT_MAX) begin
				tot_r[i] <= tot_r[i] + 10'h1;
			end
		end
		for (genvar s = 0; s < arrs_pkg::NSRC; s++) begin : g_sub
			// per-start subcounter
			wire logic hit = cnt_inc[i] && evt.src == 2'(s);
			always_ff @(posedge core_clk) begin
				if (!resetn || rec_clr) begin
					sub_r[i][s] <= 8'h0;
				end else if (hit && sub_r[i][s] != arrs_pkg::SUB_MAX) begin
					sub_r[i][s] <= sub_r[i][s] + 8'h1;
				end
			end
		end
	end

	// alarm total, first subcounter and ceilings
	alarm_total_inc_a: assert property (
		cnt_inc[5] && tot_r[5] < arrs_pkg::TOT_MAX && !rec_clr
		|=> tot_r[5] == $past(tot_r[5]) + 10'h1)
		else $error("alarm total missed a count");
	sub_sat_a: assert property (
		sub_r[4][1] == arrs_pkg::SUB_MAX && !rec_clr |=> sub_r[4][1] == arrs_pkg::SUB_MAX)
		else $error("subcounter left its maximum");
	sub_first_a: assert property (
		evt.shot_done && evt.shot_num == 3'h1 && evt.src == 2'h0 && !rec_clr
		&& sub_r[0][0] < arrs_pkg::SUB_MAX && tot_r[0] < arrs_pkg::TOT_MAX
		|=> sub_r[0][0] == $past(sub_r[0][0]) + 8'h1 && tot_r[0] == $past(tot_r[0]) + 10'h1)
		else $error("shot one start a count missed");

	// ------------------------------------------------
	// sequence history stack
	// ------------------------------------------------
	wire logic [2:0] shots_c = (evt.shots > arrs_pkg::SHOT_MAX)
		? arrs_pkg::SHOT_MAX : evt.shots;
	wire logic [4:0] hist_new = {2'h0, shots_c}
		+ (evt.final_trip ? arrs_pkg::TRIP_ADD : 5'h0);

	always_ff @(posedge core_clk) begin
		if (!resetn || rec_clr) begin
			for (int k = 0; k <= arrs_pkg::NSLOT; k++) begin
				hist_r[k] <= 5'h0;
			end
		end else if (evt.seq_end) begin
			hist_r[0] <= hist_new;
			for (int k = 1; k <= arrs_pkg::NSLOT; k++) begin
				hist_r[k] <= hist_r[k-1];
			end
		end
	end

	// history main entry and hold
	hist_main_a: assert property (
		evt.seq_end && !evt.final_trip && evt.shots <= 3'h5 && !rec_clr
		|=> hist_r[0] == 5'($past(evt.shots)))
		else $error("shot count not stored");
	hist_hold_a: assert property (
		!evt.seq_end && !rec_clr
		|=> hist_r[0] == $past(hist_r[0]) && hist_r[4] == $past(hist_r[4]))
		else $error("history moved without a sequence end");

	// ------------------------------------------------
	// switch group and display select registers
	// ------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			for (int g = 0; g < arrs_pkg::NSGB; g++) begin
				sgb_r[g] <= 8'h0;
			end
			for (int g = 0; g < arrs_pkg::NSGR; g++) begin
				sgr_r[g] <= 7'h0;
			end
			dsel_r <= 4'h0;
		end else if (wr_b0) begin
			for (int g = 0; g < arrs_pkg::NSGB; g++) begin
				if (idx == arrs_pkg::IDX_SGB0 + 6'(g)) begin
					sgb_r[g] <= wb_dat_i[7:0];
				end
			end
			for (int g = 0; g < arrs_pkg::NSGR; g++) begin
				if (idx == arrs_pkg::IDX_SGR0 + 6'(g)) begin
					sgr_r[g] <= wb_dat_i[6:0];
				end
			end
			if (idx == arrs_pkg::IDX_DSEL) begin
				dsel_r <= wb_dat_i[3:0];
			end
		end
	end

	// ------------------------------------------------
	// read mux
	// ------------------------------------------------
	// main records by address code, for bus and display
	function automatic logic [11:0] main_rec(input logic [5:0] a);
		logic [11:0] v;
		v = 12'h0;
		if (a == arrs_pkg::IDX_DISP) begin
			v = disp_word;
		end else if (a >= arrs_pkg::IDX_TOT0 && a <= arrs_pkg::IDX_TRIP) begin
			v = {2'h0, tot_r[3'(a - arrs_pkg::IDX_TOT0)]};
		end else if (a == arrs_pkg::IDX_HIST) begin
			v = {7'h0, hist_r[0]};
		end
		return v;
	endfunction

	always_comb begin
		rd_nxt = {20'h0, main_rec(idx)};
		if (idx >= arrs_pkg::IDX_SUB0 && idx < arrs_pkg::IDX_SLOT1) begin
			rd_nxt = {24'h0, sub_r[3'((idx - arrs_pkg::IDX_SUB0) >> 2)]
				[2'(idx - arrs_pkg::IDX_SUB0)]};
		end else if (idx >= arrs_pkg::IDX_SLOT1 && idx < arrs_pkg::IDX_SGB0) begin
			rd_nxt = {27'h0, hist_r[3'(idx - arrs_pkg::IDX_SLOT1) + 3'h1]};
		end else if (idx >= arrs_pkg::IDX_SGB0
			&& idx < arrs_pkg::IDX_SGB0 + 6'(arrs_pkg::NSGB)) begin
			// weights 1,2,4.. so the checksum is the word itself
			rd_nxt = {24'h0, sgb_r[2'(idx - arrs_pkg::IDX_SGB0)]};
		end else if (idx >= arrs_pkg::IDX_SGR0 && idx < arrs_pkg::IDX_DSEL) begin
			rd_nxt = {25'h0, sgr_r[4'(idx - arrs_pkg::IDX_SGR0)]};
		end else if (idx == arrs_pkg::IDX_DSEL) begin
			rd_nxt = {28'h0, dsel_r};
		end
	end

	// one wait-free ack per request, data with it
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0;
		end else begin
			ack_r <= req;
			dat_r <= (req && !wb_we_i) ? rd_nxt : 32'h0;
		end
	end

	// bus answer shape
	ack_pulse_a: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held past one cycle");
	idle_data_a: assert property (
		!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");

	// display: code digit and three value digits
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			disp_code  <= 4'h0;
			disp_value <= 12'h0;
		end else begin
			disp_code  <= dsel_r;
			disp_value <= main_rec({2'h0, dsel_r});
		end
	end

	// display code and left digit
	disp_code_a: assert property (
		1'b1 |=> disp_code == $past(dsel_r))
		else $error("display code lags select");
	disp_left_a: assert property (
		dsel_r == 4'h0 |=> disp_value[11:8] == 4'($past(reclose_start_a))
		+ 4'(2 * $past(reclose_start_b)) + 4'(4 * $past(reclose_start_c)))
		else $error("start digit wrong");

	// ------------------------------------------------
	// checks
	// ------------------------------------------------
	// record counters, history, display, routing and bus
	shot_total_sat_a: assert property (
		tot_r[4] == arrs_pkg::TOT_MAX && !rec_clr |=> tot_r[4] == arrs_pkg::TOT_MAX)
		else $error("shot total left its maximum");
	shot_total_inc_a: assert property (
		cnt_inc[1] && tot_r[1] < arrs_pkg::TOT_MAX && !rec_clr
		|=> tot_r[1] == $past(tot_r[1]) + 10'h1)
		else $error("shot two total missed a count");
	sub_count_a: assert property (
		evt.shot_done && evt.shot_num == 3'h3 && evt.src == 2'h2
		&& sub_r[2][2] < arrs_pkg::SUB_MAX && !rec_clr
		|=> sub_r[2][2] == $past(sub_r[2][2]) + 8'h1 && sub_r[2][0] == $past(sub_r[2][0]))
		else $error("subcounter wrong");
	alarm_count_a: assert property (
		evt.alarm && evt.src == 2'h3 && sub_r[5][3] < arrs_pkg::SUB_MAX && !rec_clr
		|=> sub_r[5][3] == $past(sub_r[5][3]) + 8'h1)
		else $error("alarm subcounter missed");
	hist_trip_a: assert property (
		evt.seq_end && evt.final_trip && evt.shots <= 3'h5 && !rec_clr
		|=> hist_r[0] == 5'($past(evt.shots)) + 5'h0a)
		else $error("final trip not added to history");
	hist_shift_a: assert property (
		evt.seq_end && !rec_clr
		|=> hist_r[1] == $past(hist_r[0]) && hist_r[4] == $past(hist_r[3]))
		else $error("history did not shift");
	clear_all_a: assert property (
		rec_clr |=> tot_r[5] == 10'h0 && sub_r[0][1] == 8'h0 && hist_r[2] == 5'h0)
		else $error("record reset incomplete");
	disp_digits_a: assert property (
		dsel_r == 4'h0 |=> disp_value[3:0] == 4'($past(reclose_inhibit_input))
		+ 4'(2 * $past(reclose_control_input)) + 4'(4 * $past(blocking_input))
		&& disp_value[7:4] == {3'h0, !$past(breaker_pos_input)})
		else $error("input display digits wrong");
	link_blk_a: assert property (
		blocking_input && sgb_r[1][5] |=> start_c_routed)
		else $error("blocking not linked to start c");
	relay_map_a: assert property (
		module_signals[4] && sgr_r[4][4] |=> trip_outputs[0])
		else $error("output routing missed");
	bus_ack_a: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack timing wrong");
endmodule
`default_nettype wire

// *** core/arrs_pkg.sv ***
// constants and types of the reclose record and signal map
package arrs_pkg;
	// ------------------------------------------------
	// word indices, byte address is four times these
	// ------------------------------------------------
	localparam logic [5:0] IDX_DISP   = 6'h00;
	localparam logic [5:0] IDX_TOT0   = 6'h03;
	localparam logic [5:0] IDX_TRIP   = 6'h08;
	localparam logic [5:0] IDX_HIST   = 6'h09;
	localparam logic [5:0] IDX_SUB0   = 6'h10;
	localparam logic [5:0] IDX_SLOT1  = 6'h28;
	localparam logic [5:0] IDX_SGB0   = 6'h2c;
	localparam logic [5:0] IDX_SGR0   = 6'h30;
	localparam logic [5:0] IDX_DSEL   = 6'h3b;
	// ------------------------------------------------
	// sizes, limits and field positions
	// ------------------------------------------------
	localparam int        NCNT      = 6;
	localparam int        NSRC      = 4;
	localparam int        NSGB      = 3;
	localparam int        NSGR      = 11;
	localparam int        NOUT      = 7;
	localparam int        NSLOT     = 4;
	localparam logic [9:0] TOT_MAX  = 10'h3e7;
	localparam logic [7:0] SUB_MAX  = 8'hff;
	localparam logic [4:0] TRIP_ADD = 5'h0a;
	localparam logic [2:0] SHOT_MAX = 3'h5;
	localparam int        SW_STARTD = 0;
	localparam int        SW_SYNC   = 1;
	localparam int        SW_BREAKER_CLOSE_INHIBIT   = 2;
	localparam int        SW_INDRST = 3;
	localparam int        SW_RECRST = 4;
	localparam int        SW_LINKC  = 5;
	localparam int        GRP_BLK   = 1;
	// ------------------------------------------------
	// sequence events from the reclose sequencer
	// ------------------------------------------------
	typedef struct packed {
		logic       shot_done;
		logic [2:0] shot_num;
		logic [1:0] src;
		logic       alarm;
		logic       seq_end;
		logic [2:0] shots;
		logic       final_trip;
	} arrs_evt_t;
endpackage

// *** tb/arrs_core_tb.sv ***
// self-checking bench of the reclose record and signal map
`timescale 1ns/100ps
`default_nettype none
module arrs_core_tb;
	// ----------------------------------------
	// stimulus and wiring
	// ----------------------------------------
	logic                core_clk = 1'b0;
	logic                resetn   = 1'b0;
	logic [7:0]          adr      = 8'h00;
	logic [31:0]         dat      = 32'h0;
	logic                we       = 1'b0;
	logic                cyc      = 1'b0;
	logic [7:0]          cmd      = 8'h00;
	logic [10:0]         msig     = 11'h000;
	arrs_pkg::arrs_evt_t evt      = '0;
	logic [31:0]         rdat;
	logic                ack;
	logic [7:0]          lines;
	logic [5:0]          ctl_o;
	logic [3:0]          sig_o;
	logic [2:0]          trip_o;
	logic [3:0]          dcode;
	logic [11:0]         dval;
	logic [31:0]         q;
	int                  err_total = 0;
	int                  compares  = 0;

	always #25 core_clk = ~core_clk;

	arrs_field fld (.core_clk(core_clk), .cmd(cmd), .lines(lines));
	arrs_core dut (.core_clk(core_clk), .resetn(resetn), .wb_adr_i(adr), .wb_dat_i(dat),
		.wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(rdat),
		.wb_ack_o(ack), .reclose_start_a(lines[0]), .reclose_start_b(lines[1]),
		.reclose_start_c(lines[2]), .reclose_inhibit_input(lines[3]),
		.reclose_control_input(lines[4]), .blocking_input(lines[5]),
		.remote_reset_input(lines[6]), .breaker_pos_input(lines[7]), .evt(evt),
		.module_signals(msig), .reclose_start_d(ctl_o[0]), .synchrocheck_ok(ctl_o[1]),
		.breaker_close_inhibit(ctl_o[2]), .indicator_reset(ctl_o[3]),
		.record_reset(ctl_o[4]), .start_c_routed(ctl_o[5]), .signalling_outputs(sig_o),
		.trip_outputs(trip_o), .disp_code(dcode), .disp_value(dval));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic print_verdict;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// one classic cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [5:0] idx, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		cyc <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		dat <= d;
		do begin
			@(posedge core_clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rdat;
		cyc <= 1'b0;
		if (n >= 50) begin
			err_total++;
			print_verdict();
		end
	endtask
	task automatic rd_chk(input logic [5:0] idx, input logic [31:0] v);
		wb(1'b0, idx, 32'h0);
		check(q, v);
	endtask
	task automatic wr_chk(input logic [5:0] idx, input logic [31:0] v);
		wb(1'b1, idx, v);
		rd_chk(idx, v);
	endtask
	// one-cycle sequencer event
	task automatic ev(input logic sd, input int n, input int s, input logic al,
		input logic sq, input int sh, input logic ft);
		@(posedge core_clk);
		evt.shot_done <= sd;
		evt.shot_num <= 3'(n);
		evt.src <= 2'(s);
		evt.alarm <= al;
		evt.seq_end <= sq;
		evt.shots <= 3'(sh);
		evt.final_trip <= ft;
		@(posedge core_clk);
		evt <= '0;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_disp;
		logic [7:0] v;
		for (int i = 0; i < 128; i++) begin
			v = 8'(i);
			@(posedge core_clk);
			cmd <= {v[6], 1'b0, v[5:0]};
			tick(3);
			rd_chk(6'h00, {21'h0, v[2:0], 3'h0, ~v[6], 1'b0, v[5:3]});
		end
		cmd <= 8'h00;
		rd_chk(6'h01, 32'h0);
	endtask
	task automatic t_count;
		for (int n = 1; n <= 5; n++) begin
			for (int s = 0; s < 4; s++) begin
				repeat (s + 1) ev(1'b1, n, s, 1'b0, 1'b0, 0, 1'b0);
			end
		end
		for (int s = 0; s < 4; s++) begin
			repeat (s + 1) ev(1'b0, 0, s, 1'b1, 1'b0, 0, 1'b0);
		end
		for (int n = 0; n < 5; n++) begin
			rd_chk(6'(3 + n), 32'h0a);
			for (int s = 0; s < 4; s++) rd_chk(6'(16 + 4 * n + s), 32'(s + 1));
		end
		rd_chk(6'h08, 32'h0a);
		for (int s = 0; s < 4; s++) rd_chk(6'(36 + s), 32'(s + 1));
	endtask
	task automatic t_hist;
		logic [4:0] x [6] = '{5'h01, 5'h0c, 5'h05, 5'h0a, 5'h04, 5'h03};
		for (int i = 0; i < 6; i++) ev(1'b0, 0, 0, 1'b0, 1'b1, x[i] % 10, x[i] >= 10);
		rd_chk(6'h09, 32'h03);
		for (int k = 1; k <= 4; k++) rd_chk(6'(39 + k), 32'(x[5 - k]));
		wb(1'b1, 6'h3b, 32'h9);
		tick(2);
		check(dcode, 32'h9);
		check(dval, 32'h3);
		wb(1'b1, 6'h3b, 32'h0);
		tick(2);
		check(dval, 32'h010);
	endtask
	task automatic t_sat;
		repeat (1000) ev(1'b1, 5, 1, 1'b0, 1'b0, 0, 1'b0);
		rd_chk(6'h07, 32'h3e7);
		rd_chk(6'h21, 32'hff);
	endtask
	task automatic t_rrst;
		logic [5:0] l [6] = '{6'h03, 6'h07, 6'h08, 6'h09, 6'h21, 6'h2b};
		wr_chk(6'h2e, 32'h10);
		cmd <= 8'h40;
		tick(4);
		check(ctl_o, 32'h18);
		cmd <= 8'h00;
		tick(3);
		for (int i = 0; i < 6; i++) rd_chk(l[i], 32'h0);
		wr_chk(6'h2e, 32'h0);
	endtask
	task automatic t_ctl;
		logic [5:0] e;
		for (int k = 0; k < 8; k++) begin
			wr_chk(6'h2d, 32'(1 << k));
			cmd <= 8'h20;
			tick(4);
			e = (k < 4) ? 6'(1 << k) : (k == 4) ? 6'h18 : (k == 5) ? 6'h20 : 6'h00;
			check(ctl_o, e);
			cmd <= 8'h00;
			tick(3);
		end
		wr_chk(6'h2d, 32'h0);
		wr_chk(6'h2c, 32'h21);
		cmd <= 8'h10;
		tick(4);
		check(ctl_o, 32'h01);
		cmd <= 8'h00;
	endtask
	task automatic t_out;
		for (int g = 0; g < 11; g++) begin
			wr_chk(6'(48 + g), 32'(1 << (g % 7)));
			msig <= 11'h7ff ^ 11'(1 << g);
			tick(3);
			check({trip_o, sig_o}, 32'h0);
			msig <= 11'(1 << g);
			tick(3);
			check({trip_o, sig_o}, 32'(1 << (g % 7)));
			msig <= 11'h000;
			wb(1'b1, 6'(48 + g), 32'h0);
		end
	endtask

	initial begin
		repeat (8) @(posedge core_clk);
		resetn <= 1'b1;
		t_disp();
		t_count();
		t_hist();
		t_sat();
		t_rrst();
		t_ctl();
		t_out();
		print_verdict();
	end
endmodule
`default_nettype wire

// *** tb/arrs_field.sv ***
// field wiring model: relay assembly inputs and breaker contact
`timescale 1ns/100ps
`default_nettype none
module arrs_field (
	// clock
	input  wire logic       core_clk,
	// bench command: a, b, c, inhibit, control, blocking, remote, breaker open
	input  wire logic [7:0] cmd,
	// lines into the relay module, bit 7 high while breaker open
	output var  logic [7:0] lines
);
	// contacts settle one cycle after the command
	always_ff @(posedge core_clk) begin
		lines <= cmd;
	end
endmodule
`default_nettype wire
